/* File: design/adc_cfg_pkg.sv */
// Constants, types and field layout of the input and reload configuration bank
package adc_cfg_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [6:0] INPUT_CFG_ADDR = 7'h11;
	localparam logic [6:0] RELOAD_ADDR = 7'h13;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CHA_SE_BIT = 5;
	localparam int CHB_SE_BIT = 4;
	localparam int DLL_OFF_BIT = 2;
	localparam int AZ_BIT = 0;
	localparam int RELOAD_BIT = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic SE_RESET = 1'b0;
	localparam logic DLL_OFF_RESET = 1'b0;
	localparam logic AZ_RESET_SLOW = 1'b1;
	localparam logic AZ_RESET_FAST = 1'b0;
	localparam logic RELOAD_RESET = 1'b0;

	// ****************************************
	// Serial frame layout
	// ****************************************
	localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h0f;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		GRADE_SLOW = 2'h0,
		GRADE_MID = 2'h1,
		GRADE_FAST = 2'h2
	} grade_t;

	typedef enum logic [3:0] {
		SPI_IDLE = 4'h1,
		SPI_ADDR = 4'h2,
		SPI_DATA = 4'h4,
		SPI_DONE = 4'h8
	} spi_state_t;

	typedef struct packed {
		logic cha_se;
		logic chb_se;
		logic dll_off;
		logic az;
	} input_cfg_t;

	function automatic input_cfg_t cfg_reset(input grade_t g);
		input_cfg_t c;
		c.cha_se = SE_RESET;
		c.chb_se = SE_RESET;
		c.dll_off = DLL_OFF_RESET;
		c.az = (g == GRADE_FAST) ? AZ_RESET_FAST : AZ_RESET_SLOW;
		return c;
	endfunction

endpackage

/* File: design/pin_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic din,
	output logic dout
);
	logic meta_reg;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			meta_reg <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule

/* File: design/adc_input_cfg.sv */
// Serial-port register bank: input type, delay loop, auto-zero, bit-map reload
//
// Summary of operation
// - Bit 5 of input config picks channel A single-ended (1) or differential (0).
// - Bit 4 of input config picks channel B single-ended (1) or differential (0).
// - Bit 2 powers down delay loop; window then half period instead of quarter.
// - Delay-loop power-down acts only on the fastest speed grade.
// - Bit 0 of input config turns auto-zero on (1) or off (0).
// - Auto-zero resets on for the slower grades, off for the fastest.
`timescale 1ns/1ps
module adc_input_cfg import adc_cfg_pkg::*; #(
	parameter grade_t GRADE = GRADE_FAST
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sen_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdout,
	output logic sdout_oe,
	output logic chan_a_single_ended,
	output logic chan_b_single_ended,
	output logic sample_delay_loop_off,
	output logic sample_window_half,
	output logic auto_zero_on,
	output logic bit_map_reload
);
	localparam input_cfg_t CFG_RESET = cfg_reset(GRADE);
	localparam logic DLL_EFFECTIVE = (GRADE == GRADE_FAST);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic sen_n_s;
	logic sclk_s;
	logic sdi_s;
	logic sclk_d_reg;

	pin_sync #(.RST_VAL(1'b1)) u_sync_sen (.mclk(mclk), .rstn(rstn), .din(sen_n), .dout(sen_n_s));
	pin_sync #(.RST_VAL(1'b0)) u_sync_sclk (.mclk(mclk), .rstn(rstn), .din(sclk), .dout(sclk_s));
	pin_sync #(.RST_VAL(1'b0)) u_sync_sdi (.mclk(mclk), .rstn(rstn), .din(sdi), .dout(sdi_s));

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_s;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	assign sclk_rise = sclk_s & ~sclk_d_reg;
	assign sclk_fall = ~sclk_s & sclk_d_reg;

	// ****************************************
	// Serial frame engine
	// ****************************************
	spi_state_t state_reg;
	logic [4:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] rd_shift_reg;
	logic [6:0] addr_reg;
	logic rw_reg;
	logic addr_done;
	logic data_done;
	logic [7:0] rd_data;
	logic [7:0] wr_data;
	logic wr_stb;
	logic sdout_reg;

	assign addr_done = (state_reg == SPI_ADDR) && sclk_rise && (bit_cnt_reg == ADDR_LAST_BIT);
	assign data_done = (state_reg == SPI_DATA) && sclk_rise && (bit_cnt_reg == FRAME_LAST_BIT);
	assign wr_data = {shift_reg[6:0], sdi_s};
	assign wr_stb = data_done && !rw_reg;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_reg <= SPI_IDLE;
			bit_cnt_reg <= 5'h00;
		end else if (sen_n_s) begin
			state_reg <= SPI_IDLE;
			bit_cnt_reg <= 5'h00;
		end else begin
			case (state_reg)
				SPI_IDLE: begin
					state_reg <= SPI_ADDR;
				end
				SPI_ADDR: begin
					if (sclk_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
					end
					if (addr_done) begin
						state_reg <= SPI_DATA;
					end
				end
				SPI_DATA: begin
					if (sclk_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
					end
					if (data_done) begin
						state_reg <= SPI_DONE;
					end
				end
				SPI_DONE: begin
					state_reg <= SPI_DONE;
				end
				default: begin
					state_reg <= SPI_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			shift_reg <= 8'h00;
			addr_reg <= 7'h00;
			rw_reg <= 1'b0;
		end else if (sclk_rise && !sen_n_s) begin
			shift_reg <= wr_data;
			if (addr_done) begin
				rw_reg <= shift_reg[6];
				addr_reg <= wr_data[6:0];
			end
		end
	end

	// Read data is driven on falling edges so the host samples on rising ones
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rd_shift_reg <= 8'h00;
			sdout_reg <= 1'b0;
		end else if (addr_done) begin
			rd_shift_reg <= rd_data;
		end else if ((state_reg == SPI_DATA) && sclk_fall) begin
			sdout_reg <= rd_shift_reg[7];
			rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
		end
	end

	assign sdout = sdout_reg;
	assign sdout_oe = (state_reg == SPI_DATA) && rw_reg && !sen_n_s;

	// ****************************************
	// Registers
	// ****************************************
	input_cfg_t cfg_reg;
	logic reload_bit_reg;
	logic reload_pulse_reg;
	logic reload_fire;

	assign reload_fire = wr_stb && (addr_reg == RELOAD_ADDR) && reload_bit_reg
		&& !wr_data[RELOAD_BIT];

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cfg_reg <= CFG_RESET;
		end else if (reload_fire) begin
			cfg_reg <= CFG_RESET;
		end else if (wr_stb && (addr_reg == INPUT_CFG_ADDR)) begin
			cfg_reg.cha_se <= wr_data[CHA_SE_BIT];
			cfg_reg.chb_se <= wr_data[CHB_SE_BIT];
			cfg_reg.dll_off <= wr_data[DLL_OFF_BIT];
			cfg_reg.az <= wr_data[AZ_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			reload_bit_reg <= RELOAD_RESET;
		end else if (wr_stb && (addr_reg == RELOAD_ADDR)) begin
			reload_bit_reg <= wr_data[RELOAD_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			reload_pulse_reg <= 1'b0;
		end else begin
			reload_pulse_reg <= reload_fire;
		end
	end

	always_comb begin
		rd_data = UNMAPPED_READ;
		if (wr_data[6:0] == INPUT_CFG_ADDR) begin
			rd_data[CHA_SE_BIT] = cfg_reg.cha_se;
			rd_data[CHB_SE_BIT] = cfg_reg.chb_se;
			rd_data[DLL_OFF_BIT] = cfg_reg.dll_off;
			rd_data[AZ_BIT] = cfg_reg.az;
		end else if (wr_data[6:0] == RELOAD_ADDR) begin
			rd_data[RELOAD_BIT] = reload_bit_reg;
		end
	end

	assign chan_a_single_ended = cfg_reg.cha_se;
	assign chan_b_single_ended = cfg_reg.chb_se;
	assign sample_delay_loop_off = cfg_reg.dll_off & DLL_EFFECTIVE;
	assign sample_window_half = cfg_reg.dll_off & DLL_EFFECTIVE;
	assign auto_zero_on = cfg_reg.az;
	assign bit_map_reload = reload_pulse_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	logic cfg_wr;
	assign cfg_wr = wr_stb && (addr_reg == INPUT_CFG_ADDR);

	cha_type_a: assert property (cfg_wr |=> chan_a_single_ended == $past(wr_data[CHA_SE_BIT]))
		else $error("channel A input type not taken from write");
	chb_type_a: assert property (cfg_wr |=> chan_b_single_ended == $past(wr_data[CHB_SE_BIT]))
		else $error("channel B input type not taken from write");
	window_half_a: assert property (cfg_wr && wr_data[DLL_OFF_BIT] && DLL_EFFECTIVE |=> sample_window_half [*2] or sen_n_s)
		else $error("sampling window not widened");
	dll_grade_a: assert property (!DLL_EFFECTIVE |-> !sample_delay_loop_off && !sample_window_half)
		else $error("delay loop power-down acted on slow grade");
	az_write_a: assert property (cfg_wr |=> auto_zero_on == $past(wr_data[AZ_BIT]))
		else $error("auto-zero not taken from write");
	az_reset_a: assert property ($rose(rstn) |-> auto_zero_on == (GRADE != GRADE_FAST))
		else $error("auto-zero reset value wrong for grade");
	reload_clear_a: assert property (reload_fire |=> bit_map_reload && cfg_reg == CFG_RESET ##1 !bit_map_reload)
		else $error("reload did not clear earlier writes");

	cfg_write_c: cover property (cfg_wr);
	reload_c: cover property (reload_fire ##1 bit_map_reload);
	read_frame_c: cover property (addr_done && shift_reg[6] ##[1:200] data_done);
endmodule

/* File: verif/cfg_host.sv */
// Host controller model driving the serial configuration port
`timescale 1ns/1ps
module cfg_host (
	input wire logic mclk,
	output logic sen_n,
	output logic sclk,
	output logic sdi,
	input wire logic sdout,
	output logic [7:0] rdata
);
	initial begin
		sen_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		rdata = 8'h00;
	end

	// One register per frame, MSB first, sclk high for 4 mclk and low for 8 mclk
	task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] data);
		logic [15:0] f;
		f = {rw, addr, data};
		@(negedge mclk);
		sen_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (4) @(negedge mclk);
			sdi = f[i];
			repeat (4) @(negedge mclk);
			if (i < 8) rdata[i] = sdout;
			sclk = 1'b1;
			repeat (4) @(negedge mclk);
			sclk = 1'b0;
		end
		repeat (8) @(negedge mclk);
		sen_n = 1'b1;
		// Released data line does not keep its last level
		sdi = ~sdi;
		repeat (6) @(negedge mclk);
	endtask
endmodule

/* File: verif/tb_adc_input_cfg.sv */
// Self-checking bench for the input and reload configuration bank
`timescale 1ns/1ps
module tb_adc_input_cfg import adc_cfg_pkg::*; ();
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic sen_n, sclk, sdi, sdout, sdout_oe, bit_map_reload;
	logic a_f, b_f, d_f, h_f, z_f, a_s, b_s, d_s, h_s, z_s;
	logic a_m, b_m, d_m, h_m, z_m;
	logic [7:0] outs_f, outs_s, outs_m;
	int miscompares = 0;
	int check_count = 0;
	int pulses = 0;
	int oe_seen = 0;
	// Stimulus assumes a sample rate below 40 MSPS; reserved bits stay 0
	localparam logic [7:0] PATS [5] = '{8'h20, 8'h10, 8'h04, 8'h01, 8'h35};

	always #5 mclk = ~mclk;
	assign outs_f = {2'b00, a_f, b_f, h_f, d_f, 1'b0, z_f};
	assign outs_s = {2'b00, a_s, b_s, h_s, d_s, 1'b0, z_s};
	assign outs_m = {2'b00, a_m, b_m, h_m, d_m, 1'b0, z_m};
	always @(posedge mclk) if (bit_map_reload === 1'b1) pulses++;
	always @(posedge mclk) if (sdout_oe === 1'b1) oe_seen++;

	cfg_host u_host (.mclk(mclk), .sen_n(sen_n), .sclk(sclk), .sdi(sdi), .sdout(sdout),
		.rdata());
	adc_input_cfg #(.GRADE(GRADE_FAST)) u_dut (.mclk(mclk), .rstn(rstn), .sen_n(sen_n),
		.sclk(sclk), .sdi(sdi), .sdout(sdout), .sdout_oe(sdout_oe), .chan_a_single_ended(a_f),
		.chan_b_single_ended(b_f), .sample_delay_loop_off(d_f), .sample_window_half(h_f),
		.auto_zero_on(z_f), .bit_map_reload(bit_map_reload));
	adc_input_cfg #(.GRADE(GRADE_SLOW)) u_slow (.mclk(mclk), .rstn(rstn), .sen_n(sen_n),
		.sclk(sclk), .sdi(sdi), .sdout(), .sdout_oe(), .chan_a_single_ended(a_s),
		.chan_b_single_ended(b_s), .sample_delay_loop_off(d_s), .sample_window_half(h_s),
		.auto_zero_on(z_s), .bit_map_reload());
	adc_input_cfg #(.GRADE(GRADE_MID)) u_mid (.mclk(mclk), .rstn(rstn), .sen_n(sen_n),
		.sclk(sclk), .sdi(sdi), .sdout(), .sdout_oe(), .chan_a_single_ended(a_m),
		.chan_b_single_ended(b_m), .sample_delay_loop_off(d_m), .sample_window_half(h_m),
		.auto_zero_on(z_m), .bit_map_reload());

	// *****************
	// Helpers
	// *****************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] expo(input logic [7:0] d, input logic fast);
		return {2'b00, d[5], d[4], d[2] & fast, d[2] & fast, 1'b0, d[0]};
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// *****************
	// Scenarios
	// *****************
	task automatic t_reset();
		chk(outs_f, 8'h00);
		chk(outs_s, 8'h01);
		chk(outs_m, 8'h01);
		chk({6'h00, sdout_oe, bit_map_reload}, 8'h00);
		// Configuration sequence opens with the bit-map reload
		pulses = 0;
		u_host.xfer(1'b0, RELOAD_ADDR, 8'h01);
		u_host.xfer(1'b0, RELOAD_ADDR, 8'h00);
		chk(pulses[7:0], 8'h01);
		chk(outs_f, 8'h00);
	endtask

	task automatic t_fields();
		foreach (PATS[i]) begin
			oe_seen = 0;
			u_host.xfer(1'b0, INPUT_CFG_ADDR, PATS[i]);
			chk({7'h00, oe_seen != 0}, 8'h00);
			chk(outs_f, expo(PATS[i], 1'b1));
			chk(outs_s, expo(PATS[i], 1'b0));
			chk(outs_m, expo(PATS[i], 1'b0));
			u_host.xfer(1'b1, INPUT_CFG_ADDR, 8'h00);
			chk({7'h00, oe_seen != 0}, 8'h01);
			chk(u_host.rdata, PATS[i] & 8'h35);
		end
	endtask

	task automatic t_unmapped();
		u_host.xfer(1'b0, 7'h12, 8'h00);
		chk(outs_f, expo(8'h35, 1'b1));
		u_host.xfer(1'b1, 7'h12, 8'h00);
		chk(u_host.rdata, UNMAPPED_READ);
	endtask

	task automatic t_reload();
		u_host.xfer(1'b0, INPUT_CFG_ADDR, 8'h31);
		pulses = 0;
		u_host.xfer(1'b0, RELOAD_ADDR, 8'h01);
		chk(outs_f, 8'h31);
		chk(pulses[7:0], 8'h00);
		u_host.xfer(1'b0, RELOAD_ADDR, 8'h00);
		chk(pulses[7:0], 8'h01);
		chk(outs_f, 8'h00);
		chk(outs_s, 8'h01);
		chk(outs_m, 8'h01);
		u_host.xfer(1'b0, RELOAD_ADDR, 8'h00);
		chk(pulses[7:0], 8'h01);
		// Writes after the reload open a fresh sequence and must land
		u_host.xfer(1'b0, INPUT_CFG_ADDR, 8'h21);
		chk(outs_f, 8'h21);
	endtask

	initial begin
		repeat (5) @(negedge mclk);
		rstn = 1'b1;
		repeat (5) @(negedge mclk);
		t_reset();
		t_fields();
		t_unmapped();
		t_reload();
		close_out();
	end

	initial begin
		repeat (100000) @(posedge mclk);
		miscompares++;
		close_out();
	end
endmodule
